// file: logic/pllsw_pkg.sv
// Shared constants and types for the reference clock switchover block
package pllsw_pkg;

    // Clock and loss detection timing
    localparam int          REF_CLK_PERIOD_NS = 10;      // 100 MHz system clock
    localparam int          LOSS_TIME_NS      = 160;     // Quiet time that marks a clock lost
    localparam int          LOSS_CYCLES_I     = (LOSS_TIME_NS + REF_CLK_PERIOD_NS - 1)
                                                / REF_CLK_PERIOD_NS;
    localparam int          LOSS_CNT_W        = 6;       // Wide enough for the loss count
    localparam logic [5:0]  LOSS_CYCLES       = 6'(LOSS_CYCLES_I);
    localparam logic [5:0]  LOSS_CNT_MAX      = 6'h3F;   // Saturation value

    // Phase tap geometry
    localparam int          TAP_W             = 3;       // Eight oscillator taps
    localparam logic [2:0]  TAP_LAST          = 3'h7;
    localparam logic [2:0]  TAP_FIRST         = 3'h0;
    localparam int          COARSE_W          = 8;       // Whole oscillator periods
    localparam logic [7:0]  COARSE_ONE        = 8'h01;
    localparam logic [2:0]  TAP_ONE           = 3'h1;

    // Register bus
    localparam int          ADDR_W            = 4;
    localparam int          DATA_W            = 8;
    localparam logic [3:0]  REG_CTRL          = 4'h0;
    localparam logic [3:0]  REG_STATUS        = 4'h1;
    localparam logic [3:0]  REG_MASK          = 4'h2;
    localparam logic [3:0]  REG_STATE         = 4'h3;
    localparam logic [3:0]  REG_PHASE         = 4'h4;
    localparam logic [3:0]  REG_COARSE        = 4'h5;

    // Control register fields
    localparam int          CTRL_AUTO_BIT     = 0;
    localparam logic [7:0]  CTRL_RESET        = 8'h01;   // Automatic switchover on
    localparam int          PH_UP_BIT         = 0;       // Step direction, 1 = later tap
    localparam int          PH_GO_BIT         = 1;       // Request one step

    // Status and mask fields
    localparam int          ST_W              = 4;
    localparam int          ST_SWITCH         = 0;
    localparam int          ST_LOST_A         = 1;
    localparam int          ST_LOST_B         = 2;
    localparam int          ST_PHASE          = 3;
    localparam logic [3:0]  ST_RESET          = 4'h0;
    localparam logic [3:0]  MASK_RESET        = 4'h0;

    // State register fields
    localparam int          SR_SEL            = 0;
    localparam int          SR_LOST_A         = 1;
    localparam int          SR_LOST_B         = 2;
    localparam int          SR_WAIT           = 3;
    localparam int          SR_BUSY           = 4;

    // Switchover state machine
    typedef enum logic [1:0] {
        PLLSW_IDLE = 2'b00,
        PLLSW_WAIT = 2'b01
    } pllsw_state_e;

    // Input select codes
    localparam logic        SEL_A             = 1'b0;
    localparam logic        SEL_B             = 1'b1;

endpackage

// file: logic/pllsw_phase_if.sv
// Carrier between switchover core and phase stepper
`timescale 1ns/10ps
`default_nettype none

interface pllsw_phase_if;
    import pllsw_pkg::*;
    logic                step_req;   // One-cycle request for a step
    logic                step_up;    // Direction of the requested step
    logic                busy;       // Step pending, waiting for scan edge
    logic                step_done;  // One-cycle pulse, step applied
    logic [TAP_W-1:0]    tap;        // Current fine tap
    logic [COARSE_W-1:0] coarse;     // Current coarse delay

    modport ctrl    (output step_req, output step_up,
                     input busy, input step_done, input tap, input coarse);
    modport stepper (input step_req, input step_up,
                     output busy, output step_done, output tap, output coarse);
endinterface

`default_nettype wire

// file: logic/pllsw_phase_step.sv
// Dynamic phase stepper over the eight oscillator taps
`timescale 1ns/10ps
`default_nettype none

module pllsw_phase_step
    import pllsw_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    rst,
    input  wire logic    scan_clk,
    pllsw_phase_if.stepper ph
);

    logic scan_q;            // Previous scan clock sample
    logic pend_up;           // Latched direction
    logic scan_rise;         // Scan clock rising edge

    assign scan_rise = scan_clk & ~scan_q;

    // Scan clock edge detect; input is synchronous already
    always_ff @(posedge clk) begin
        if (rst) begin
            scan_q <= 1'b0;
        end else begin
            scan_q <= scan_clk;
        end
    end

    // Pending step; requests while busy are dropped, one step at a time
    always_ff @(posedge clk) begin
        if (rst) begin
            ph.busy <= 1'b0;
            pend_up <= 1'b0;
        end else if (ph.busy && scan_rise) begin
            ph.busy <= 1'b0;
        end else if (!ph.busy && ph.step_req) begin
            ph.busy <= 1'b1;
            pend_up <= ph.step_up;
        end
    end

    // Tap and coarse update on the first scan edge after a request
    always_ff @(posedge clk) begin
        if (rst) begin
            ph.tap       <= TAP_FIRST;
            ph.coarse    <= '0;
            ph.step_done <= 1'b0;
        end else begin
            ph.step_done <= ph.busy && scan_rise;
            if (ph.busy && scan_rise) begin
                if (pend_up) begin
                    ph.tap <= ph.tap + TAP_ONE;
                    if (ph.tap == TAP_LAST) begin
                        ph.coarse <= ph.coarse + COARSE_ONE;
                    end
                end else begin
                    ph.tap <= ph.tap - TAP_ONE;
                    if (ph.tap == TAP_FIRST) begin
                        ph.coarse <= ph.coarse - COARSE_ONE;
                    end
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // A pending step completes on the first scan edge
    a_step_one_scan: assert property (ph.busy && scan_rise |=> ph.step_done && !ph.busy)
        else $error("Phase step did not complete on scan edge");

    // Tap wrap carries into the coarse delay
    a_tap_wrap_coarse: assert property (ph.busy && scan_rise && pend_up && ph.tap == TAP_LAST
        |=> ph.tap == TAP_FIRST && ph.coarse == $past(ph.coarse) + COARSE_ONE)
        else $error("Tap wrap did not add a coarse period");

endmodule

`default_nettype wire

// file: logic/pllsw_top.sv
// Reference clock switchover control with loss flags and phase stepping
`timescale 1ns/10ps
`default_nettype none

module pllsw_top
    import pllsw_pkg::*;
(
    input  wire logic                REF_CLK,
    input  wire logic                SYS_RST,
    input  wire logic                REF_CLOCK_A,
    input  wire logic                REF_CLOCK_B,
    input  wire logic                SWITCH_REQ,
    input  wire logic                SCAN_CLK,
    input  wire logic [ADDR_W-1:0]   ADDR,
    input  wire logic [DATA_W-1:0]   WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output logic      [DATA_W-1:0]   RDATA,
    output logic                     ACTIVE_CLK,
    output logic                     REF_A_LOST_FLAG,
    output logic                     REF_B_LOST_FLAG,
    output logic      [TAP_W-1:0]    PHASE_TAP,
    output logic      [COARSE_W-1:0] COARSE_DELAY,
    output logic                     IRQ
);

    // Saturating increment shared by both loss counters
    function automatic logic [LOSS_CNT_W-1:0] sat_inc(input logic [LOSS_CNT_W-1:0] v);
        if (v == LOSS_CNT_MAX) begin
            return v;
        end
        return v + 6'h01;
    endfunction

    // Register selection used by writes; reads decode ADDR in the read multiplexer
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        return a == r;
    endfunction

    pllsw_phase_if ph ();                    // Link to the phase stepper

    logic [1:0]            ref_now;          // Reference clocks, index 0 = A
    logic [1:0]            ref_q;            // Previous reference samples
    logic [LOSS_CNT_W-1:0] idle_cnt [2];     // Cycles since last reference edge
    logic [1:0]            lost;             // Registered loss flags
    logic [1:0]            lost_q;           // Loss flags one cycle ago
    logic                  req_q;            // Previous request sample
    logic                  req_rise;         // Request rising edge
    logic                  auto_go;          // Automatic switchover trigger
    pllsw_state_e          state;            // Switchover state
    pllsw_state_e          next_state;
    logic                  sel;              // Selected input
    logic                  next_sel;
    logic                  target;           // Input being switched to
    logic                  next_target;
    logic                  switch_done;      // One-cycle completion pulse
    logic [DATA_W-1:0]     ctrl;             // Control register
    logic [ST_W-1:0]       status;           // Sticky event bits
    logic [ST_W-1:0]       mask;             // Interrupt mask
    logic [ST_W-1:0]       events;           // Event pulses this cycle
    logic [DATA_W-1:0]     rd_mux;           // Read data before the register

    assign ref_now = {REF_CLOCK_B, REF_CLOCK_A};

    // Reference sample history for edge detection
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ref_q <= 2'h0;
        end else begin
            ref_q <= ref_now;
        end
    end

    // Loss counters; each counts cycles since its own reference last changed
    always_ff @(posedge REF_CLK) begin
        for (int i = 0; i < 2; i++) begin
            if (SYS_RST) begin
                idle_cnt[i] <= '0;
            end else if (ref_now[i] != ref_q[i]) begin
                idle_cnt[i] <= '0;
            end else begin
                idle_cnt[i] <= sat_inc(idle_cnt[i]);
            end
        end
    end

    // Loss flags rise only after the full quiet time
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            lost   <= 2'h0;
            lost_q <= 2'h0;
        end else begin
            lost_q <= lost;
            for (int i = 0; i < 2; i++) begin
                lost[i] <= idle_cnt[i] >= LOSS_CYCLES;
            end
        end
    end

    assign REF_A_LOST_FLAG = lost[0];
    assign REF_B_LOST_FLAG = lost[1];

    // Request edge detect; the falling edge is deliberately unused
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            req_q <= 1'b0;
        end else begin
            req_q <= SWITCH_REQ;
        end
    end

    assign req_rise = SWITCH_REQ & ~req_q;

    // Automatic trigger, held off while the manual request is high
    assign auto_go = ctrl[CTRL_AUTO_BIT] && !SWITCH_REQ && lost[sel];

    // Switchover decision
    always_comb begin
        next_state  = state;
        next_sel    = sel;
        next_target = target;
        switch_done = 1'b0;
        case (state)
            PLLSW_IDLE: begin
                // Manual edge beats the automatic trigger
                if (req_rise) begin
                    next_target = ~sel;
                    next_state  = PLLSW_WAIT;
                end else if (auto_go) begin
                    next_target = ~sel;
                    next_state  = PLLSW_WAIT;
                end
            end
            PLLSW_WAIT: begin
                // Hold the old input until the target is seen running
                if (!lost[target]) begin
                    next_sel    = target;
                    next_state  = PLLSW_IDLE;
                    switch_done = 1'b1;
                end
            end
            default: begin
                next_state = PLLSW_IDLE;
            end
        endcase
    end

    // Switchover state registers
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state  <= PLLSW_IDLE;
            sel    <= SEL_A;
            target <= SEL_A;
        end else begin
            state  <= next_state;
            sel    <= next_sel;
            target <= next_target;
        end
    end

    assign ACTIVE_CLK = sel;

    // Control and mask writes
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ctrl <= CTRL_RESET;
            mask <= MASK_RESET;
        end else if (WR) begin
            if (hit(ADDR, REG_CTRL)) begin
                ctrl <= WDATA;
            end
            if (hit(ADDR, REG_MASK)) begin
                mask <= WDATA[ST_W-1:0];
            end
        end
    end

    // A phase step is requested by a register write with the go bit
    assign ph.step_req = WR && hit(ADDR, REG_PHASE) && WDATA[PH_GO_BIT];
    assign ph.step_up  = WDATA[PH_UP_BIT];

    pllsw_phase_step u_step (
        .clk      (REF_CLK),
        .rst      (SYS_RST),
        .scan_clk (SCAN_CLK),
        .ph       (ph)
    );

    assign PHASE_TAP    = ph.tap;
    assign COARSE_DELAY = ph.coarse;

    // Event pulses: completion, new loss, phase step
    always_comb begin
        events            = '0;
        events[ST_SWITCH] = switch_done;
        events[ST_LOST_A] = lost[0] & ~lost_q[0];
        events[ST_LOST_B] = lost[1] & ~lost_q[1];
        events[ST_PHASE]  = ph.step_done;
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            status <= ST_RESET;
        end else if (WR && hit(ADDR, REG_STATUS)) begin
            status <= (status & ~WDATA[ST_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    // Level interrupt from unmasked status
    assign IRQ = |(status & mask);

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux = '0;
        case (ADDR)
            REG_CTRL:   rd_mux = ctrl;
            REG_STATUS: rd_mux[ST_W-1:0] = status;
            REG_MASK:   rd_mux[ST_W-1:0] = mask;
            REG_STATE: begin
                rd_mux[SR_SEL]    = sel;
                rd_mux[SR_LOST_A] = lost[0];
                rd_mux[SR_LOST_B] = lost[1];
                rd_mux[SR_WAIT]   = state == PLLSW_WAIT;
                rd_mux[SR_BUSY]   = ph.busy;
            end
            REG_PHASE:  rd_mux[TAP_W-1:0] = ph.tap;
            REG_COARSE: rd_mux = ph.coarse;
            default:    rd_mux = '0;
        endcase
    end

    // Read data stand for the single cycle after the strobe
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            RDATA <= '0;
        end else if (RD) begin
            RDATA <= rd_mux;
        end else begin
            RDATA <= '0;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    // Start of a manual sequence from idle
    sequence s_manual_start;
        state == PLLSW_IDLE && req_rise;
    endsequence

    // Waiting while the target is still absent
    sequence s_wait_absent;
        state == PLLSW_WAIT && lost[target];
    endsequence

    // Rising edge moves toward the other input
    a_rise_other_input: assert property (s_manual_start
        |=> state == PLLSW_WAIT && target != $past(sel))
        else $error("Rising request did not target the other input");

    // Selection frozen while target is absent
    a_wait_holds_sel: assert property (s_wait_absent |=> sel == $past(sel)
        && state == PLLSW_WAIT)
        else $error("Selection changed while target clock absent");

    // Completion lands on the target and shows on the indicator
    a_done_shows_target: assert property (state == PLLSW_WAIT && !lost[target]
        |=> ACTIVE_CLK == $past(target) && state == PLLSW_IDLE)
        else $error("Active indicator does not show completed target");

    // Idle departure needs a rising edge or an automatic trigger
    a_start_needs_rise: assert property (state == PLLSW_IDLE ##1 state == PLLSW_WAIT
        |-> $past(req_rise) || $past(auto_go))
        else $error("Switchover began without a rising request edge");

    // Held request blocks automatic action
    a_held_req_blocks: assert property (state == PLLSW_IDLE && SWITCH_REQ && !req_rise
        |=> state == PLLSW_IDLE && sel == $past(sel))
        else $error("Switchover acted while request held high");

    // A running reference never shows as lost
    a_running_not_lost: assert property (idle_cnt[0] == '0 && idle_cnt[1] == '0
        |=> !REF_A_LOST_FLAG && !REF_B_LOST_FLAG)
        else $error("Loss flag raised on a running reference");

    // Reset leaves the first reference selected
    a_reset_first_ref: assert property (@(posedge REF_CLK) disable iff (1'b0)
        $past(SYS_RST) |-> ACTIVE_CLK == SEL_A)
        else $error("First reference not selected after reset");

    // Status bit stays set until cleared by a one
    a_sticky_holds: assert property (status[ST_SWITCH]
        && !(WR && hit(ADDR, REG_STATUS) && WDATA[ST_SWITCH]) |=> status[ST_SWITCH])
        else $error("Sticky switch status lost without a clear");

    // Read data appear only in the cycle after the strobe
    a_read_one_cycle: assert property (!RD |=> RDATA == '0)
        else $error("Read data present without a read strobe");

endmodule

`default_nettype wire

// file: tb/pllsw_ref_model.sv
// Reference clock sources and scan clock facing the switchover block
`timescale 1ns/10ps
`default_nettype none

module pllsw_ref_model (
    input  wire logic clk,
    input  wire logic run_a,
    input  wire logic run_b,
    output logic      ref_a,
    output logic      ref_b,
    output logic      scan
);
    logic [1:0] div;  // Divide by six, well below half the system rate
    logic [1:0] sdiv; // Scan clock divider

    initial begin
        div   = 2'h0;
        sdiv  = 2'h0;
        ref_a = 1'b0;
        ref_b = 1'b0;
        scan  = 1'b0;
    end

    // Both sources share one rate, so they never drift apart
    always @(posedge clk) begin
        div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        sdiv <= sdiv + 2'h1;
        // A stopped oscillator holds its last level
        if (div == 2'h2 && run_a) begin
            ref_a <= ~ref_a;
        end
        if (div == 2'h2 && run_b) begin
            ref_b <= ~ref_b;
        end
        // Scan clock runs free, period eight cycles
        if (sdiv == 2'h3) begin
            scan <= ~scan;
        end
    end
endmodule

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the reference clock switchover block
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import pllsw_pkg::*;
    logic                ref_clk    = 1'b0; // System clock
    logic                sys_rst    = 1'b1; // Synchronous reset
    logic                switch_req = 1'b0; // Manual request
    logic [ADDR_W-1:0]   addr       = '0;
    logic [DATA_W-1:0]   wdata      = '0;
    logic                wr         = 1'b0;
    logic                rd         = 1'b0;
    logic                run_a      = 1'b1; // Source A running
    logic                run_b      = 1'b1; // Source B running
    wire logic           clk_a;
    wire logic           clk_b;
    wire logic           scan_clk;
    wire logic [7:0]     rdata;
    wire logic           active;
    wire logic           lost_a;
    wire logic           lost_b;
    wire logic           irq;
    wire logic [2:0]     tap;
    wire logic [7:0]     coarse;
    int                  num_errors   = 0;
    int                  total_checks = 0;
    int                  cycles       = 0;

    pllsw_top u_pllsw_top (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .REF_CLOCK_A(clk_a),
        .REF_CLOCK_B(clk_b), .SWITCH_REQ(switch_req), .SCAN_CLK(scan_clk),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .ACTIVE_CLK(active), .REF_A_LOST_FLAG(lost_a), .REF_B_LOST_FLAG(lost_b),
        .PHASE_TAP(tap), .COARSE_DELAY(coarse), .IRQ(irq)
    );

    pllsw_ref_model u_pllsw_ref_model (
        .clk(ref_clk), .run_a(run_a), .run_b(run_b),
        .ref_a(clk_a), .ref_b(clk_b), .scan(scan_clk)
    );

    // 100 MHz system clock
    always #5 ref_clk = ~ref_clk;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Compare with case inequality so unknowns never match
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Let n edges pass, then sample settled outputs
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, input string name, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1;
        check(name, exp, rdata);
    endtask

    task automatic wait_active(input logic exp, input int n);
        int i;
        for (i = 0; i < n && active !== exp; i++) cyc(1);
        check("active", {7'h0, exp}, {7'h0, active});
    endtask

    task automatic wait_tap(input logic [2:0] exp);
        int i;
        for (i = 0; i < 40 && tap !== exp; i++) cyc(1);
        check("tap", {5'h0, exp}, {5'h0, tap});
    endtask

    task automatic t_reset();
        check("active", 8'h00, {7'h0, active});
        check("flags", 8'h00, {6'h0, lost_b, lost_a});
        reg_rd(REG_CTRL, "ctrl", CTRL_RESET);
        reg_rd(REG_STATUS, "status", {4'h0, ST_RESET});
        reg_rd(REG_MASK, "mask", {4'h0, MASK_RESET});
        reg_wr(4'hF, 8'hFF);
        reg_rd(4'hF, "unmapped", 8'h00);
    endtask

    // Press, release, press again with both sources running
    task automatic t_manual();
        reg_wr(REG_MASK, 8'h01);
        @(posedge ref_clk);
        switch_req <= 1'b1;
        cyc(1);
        check("active early", 8'h00, {7'h0, active});
        cyc(2);
        check("active", {7'h0, switch_req}, {7'h0, active});
        check("flags", 8'h00, {6'h0, lost_b, lost_a});
        check("irq", 8'h01, {7'h0, irq});
        @(posedge ref_clk);
        switch_req <= 1'b0;
        cyc(10);
        check("active", 8'h01, {7'h0, active});
        reg_wr(REG_STATUS, 8'h01);
        cyc(1);
        check("irq", 8'h00, {7'h0, irq});
        @(posedge ref_clk);
        switch_req <= 1'b1;
        cyc(3);
        check("active", 8'h00, {7'h0, active});
    endtask

    // Request held high blocks the automatic move off a lost source
    task automatic t_hold();
        @(posedge ref_clk);
        run_a <= 1'b0;
        cyc(40);
        check("lost a", 8'h01, {7'h0, lost_a});
        check("active", 8'h00, {7'h0, active});
        @(posedge ref_clk);
        switch_req <= 1'b0;
        wait_active(1'b1, 10);
        reg_rd(REG_STATUS, "status", 8'h03);
        reg_wr(REG_STATUS, 8'h03);
        reg_rd(REG_STATUS, "status", 8'h00);
        @(posedge ref_clk);
        run_a <= 1'b1;
        cyc(30);
        check("lost a", 8'h00, {7'h0, lost_a});
    endtask

    // Both sources die; the automatic move waits for its target
    // The request stays low here, so this uses the automatic path
    task automatic t_wait();
        @(posedge ref_clk);
        run_a <= 1'b0;
        run_b <= 1'b0;
        cyc(30);
        check("active", 8'h01, {7'h0, active});
        reg_rd(REG_STATE, "state", 8'h0F);
        @(posedge ref_clk);
        run_a <= 1'b1;
        wait_active(1'b0, 40);
        @(posedge ref_clk);
        run_b <= 1'b1;
        cyc(30);
        check("flags", 8'h00, {6'h0, lost_b, lost_a});
    endtask

    // Nine steps up cross the tap wrap, two down cross it back
    task automatic t_phase();
        int i;
        reg_wr(REG_STATUS, 8'h0F);
        reg_wr(REG_MASK, 8'h08);
        for (i = 1; i <= 9; i++) begin
            reg_wr(REG_PHASE, 8'h03);
            wait_tap(3'(i));
        end
        check("coarse", 8'h01, coarse);
        reg_wr(REG_PHASE, 8'h02);
        wait_tap(3'h0);
        reg_wr(REG_PHASE, 8'h02);
        wait_tap(3'h7);
        check("coarse", 8'h00, coarse);
        reg_wr(REG_COARSE, 8'hFF);
        reg_rd(REG_COARSE, "coarse reg", 8'h00);
        reg_rd(REG_PHASE, "tap reg", 8'h07);
        reg_rd(REG_STATUS, "status", 8'h08);
        check("irq", 8'h01, {7'h0, irq});
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        cyc(2);
        t_reset();
        t_manual();
        t_hold();
        t_wait();
        t_phase();
        complete_run();
    end
endmodule

`default_nettype wire
